// >>> src/tmr_pkg.sv
/*
 * Constants for the 16-bit timer: register offsets, alias operations,
 * control field positions, reset values, prescale limits and bus answers.
 * Assumes a byte-addressed AXI4-Lite slave with 12 address bits and one
 * 32-bit word per register.
 */
// Summary of operation
// - one 16-bit counter; internal, internal gated, external sync and async modes
// - control bit 15 enables the timer; clear stops counting
// - control bit 13 set stops the timer in Idle; clear keeps it running
// - control bit 12 set ignores count writes while an async write is pending
// - control bit 11 reads one while an async count write is in transfer
// - in synchronous mode the write-pending bit always reads zero
// - control bit 7 enables gated accumulation on internal clock; ignored on external
// - prescale bits 5-4 divide by 1, 8, 64 or 256
// - control bit 2 selects synchronised or async external counting; ignored internally
// - control bit 1 selects external pin clock or internal peripheral clock
// - clear, set and invert aliases sit 0x4, 0x8, 0xC above the control, count and period registers
// - unimplemented control bits, including bits 31-16, ignore writes and read zero
// - the timer can keep counting during Idle and Sleep
// - async mode counts a low-power oscillator for real-time-clock use
package tmr_pkg;
    // register map, byte addresses
    localparam logic [11:0] CTL_OFS = 12'h600;
    localparam logic [11:0] CNT_OFS = 12'h610;
    localparam logic [11:0] PER_OFS = 12'h620;
    localparam logic [11:0] STS_OFS = 12'h630;
    localparam logic [11:0] ICLR_OFS = 12'h634;
    localparam logic [11:0] IEN_OFS = 12'h638;

    // alias operation in address bits 3:2
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_CLR = 2'h1;
    localparam logic [1:0] OP_SET = 2'h2;
    localparam logic [1:0] OP_INV = 2'h3;

    // control field positions
    localparam int CTL_ON = 15;
    localparam int CTL_IDLE_STOP = 13;
    localparam int CTL_BLK = 12;
    localparam int CTL_WIP = 11;
    localparam int CTL_GATE = 7;
    localparam int CTL_PS_HI = 5;
    localparam int CTL_PS_LO = 4;
    localparam int CTL_SYNC = 2;
    localparam int CTL_CS = 1;
    localparam logic [31:0] CTL_WMASK = 32'h0000B0B6;

    // reset values
    localparam logic [31:0] CTL_RST = 32'h00000000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] PER_RST = 16'hFFFF;
    localparam logic [1:0] IRQ_RST = 2'h0;

    // prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
    localparam logic [7:0] PS_MAX_1 = 8'h00;
    localparam logic [7:0] PS_MAX_8 = 8'h07;
    localparam logic [7:0] PS_MAX_64 = 8'h3F;
    localparam logic [7:0] PS_MAX_256 = 8'hFF;

    // cycles an asynchronous count write stays in transfer
    localparam logic [1:0] ASYNC_WR_CYCLES = 2'h3;

    // interrupt status bits
    localparam int STS_WRAP = 0;
    localparam int STS_GFALL = 1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> src/tmr_timer16_top.sv
/*
 * 16-bit timer with control, count and period registers, alias writes,
 * interrupt status/clear/enable and an AXI4-Lite register slave.
 * Assumes one clock CLK_SYS, synchronous active-high RST, pin inputs
 * EXT_COUNT and GATE from outside the clock domain, and IDLE/SLEEP
 * levels from the power manager on the same clock.
 */
`timescale 1ns/10ps
module tmr_timer16_top (
    input wire logic CLK_SYS,               // peripheral clock, 40 MHz
    input wire logic RST,                   // synchronous reset, active high
    input wire logic EXT_COUNT,             // external count pin, asynchronous
    input wire logic GATE,                  // gate pin, asynchronous
    input wire logic IDLE,                  // device in Idle mode
    input wire logic SLEEP,                 // device in Sleep mode
    input wire logic [11:0] S_AXI_AWADDR,   // write address
    input wire logic S_AXI_AWVALID,         // write address valid
    output logic S_AXI_AWREADY,             // write address ready
    input wire logic [31:0] S_AXI_WDATA,    // write data
    input wire logic [3:0] S_AXI_WSTRB,     // write byte strobes
    input wire logic S_AXI_WVALID,          // write data valid
    output logic S_AXI_WREADY,              // write data ready
    output logic [1:0] S_AXI_BRESP,         // write response
    output logic S_AXI_BVALID,              // write response valid
    input wire logic S_AXI_BREADY,          // write response ready
    input wire logic [11:0] S_AXI_ARADDR,   // read address
    input wire logic S_AXI_ARVALID,         // read address valid
    output logic S_AXI_ARREADY,             // read address ready
    output logic [31:0] S_AXI_RDATA,        // read data
    output logic [1:0] S_AXI_RRESP,         // read response
    output logic S_AXI_RVALID,              // read data valid
    input wire logic S_AXI_RREADY,          // read data ready
    output logic IRQ                        // interrupt, level
);

    logic awready_q, aw_have_q, wready_q, w_have_q, bvalid_q, arready_q, rvalid_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q, rdata_q;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q, rresp_q;
    logic rd_ctl_q;
    logic [31:0] ctl_q;
    logic [15:0] cnt_q, per_q, pend_val_q;
    logic [1:0] pend_cnt_q, sts_q, ien_q;
    logic irq_q;
    logic [7:0] pre_q;
    logic ext_m_q, ext_s_q, ext_d_q, gate_m_q, gate_s_q, gate_d_q;

    // bit-wise alias operation under a byte mask
    function automatic logic [31:0] alias_op(input logic [31:0] old, input logic [31:0] din,
                                             input logic [31:0] mask, input logic [1:0] op);
        logic [31:0] bits;
        bits = din & mask;
        case (op)
            tmr_pkg::OP_CLR: alias_op = old & ~bits;
            tmr_pkg::OP_SET: alias_op = old | bits;
            tmr_pkg::OP_INV: alias_op = old ^ bits;
            default: alias_op = (old & ~mask) | bits;
        endcase
    endfunction

    // control fields
    logic on, idle_stop, blk, gate_en, sync_sel, cs, async_mode, gated, run;
    logic [1:0] ps;
    assign on = ctl_q[tmr_pkg::CTL_ON];
    assign idle_stop = ctl_q[tmr_pkg::CTL_IDLE_STOP];
    assign blk = ctl_q[tmr_pkg::CTL_BLK];
    assign gate_en = ctl_q[tmr_pkg::CTL_GATE];
    assign ps = ctl_q[tmr_pkg::CTL_PS_HI:tmr_pkg::CTL_PS_LO];
    assign sync_sel = ctl_q[tmr_pkg::CTL_SYNC];
    assign cs = ctl_q[tmr_pkg::CTL_CS];
    assign async_mode = cs & ~sync_sel;
    assign gated = ~cs & gate_en;
    // sleep halts the peripheral clock path; async counting runs on
    assign run = on & ~(idle_stop & IDLE) & ~(SLEEP & ~async_mode);

    // write channel decode
    logic wr_fire, wr_ctl, wr_cnt, wr_per, wr_iclr, wr_ien, wr_mapped;
    logic [11:0] wr_base;
    logic [1:0] wr_op;
    logic [31:0] wr_mask, ctl_new, cnt_new32, per_new32;
    assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
    assign wr_base = {aw_addr_q[11:4], 4'h0};
    assign wr_op = aw_addr_q[3:2];
    assign wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    // base offset plus 0x4/0x8/0xC selects plain, clear, set or invert
    always_comb begin
        wr_ctl = 1'b0;
        wr_cnt = 1'b0;
        wr_per = 1'b0;
        wr_iclr = 1'b0;
        wr_ien = 1'b0;
        wr_mapped = 1'b1;
        if (wr_base == tmr_pkg::CTL_OFS) begin
            wr_ctl = wr_fire;
        end else if (wr_base == tmr_pkg::CNT_OFS) begin
            wr_cnt = wr_fire;
        end else if (wr_base == tmr_pkg::PER_OFS) begin
            wr_per = wr_fire;
        end else if (aw_addr_q[11:2] == tmr_pkg::STS_OFS[11:2]) begin
            wr_mapped = 1'b1;                                          // read-only, write dropped
        end else if (aw_addr_q[11:2] == tmr_pkg::ICLR_OFS[11:2]) begin
            wr_iclr = wr_fire;
        end else if (aw_addr_q[11:2] == tmr_pkg::IEN_OFS[11:2]) begin
            wr_ien = wr_fire;
        end else begin
            wr_mapped = 1'b0;
        end
    end

    assign ctl_new = alias_op(ctl_q, w_data_q, wr_mask, wr_op) & tmr_pkg::CTL_WMASK;
    assign cnt_new32 = alias_op({16'h0000, cnt_q}, w_data_q, wr_mask, wr_op);
    assign per_new32 = alias_op({16'h0000, per_q}, w_data_q, wr_mask, wr_op);

    // write address channel
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            awready_q <= 1'b1;
            aw_have_q <= 1'b0;
            aw_addr_q <= 12'h000;
        end else if (S_AXI_AWVALID && awready_q) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
        end else if (wr_fire) begin
            awready_q <= 1'b1;
            aw_have_q <= 1'b0;
        end
    end

    // write data channel, taken independently of the address
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            wready_q <= 1'b1;
            w_have_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (S_AXI_WVALID && wready_q) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
        end else if (wr_fire) begin
            wready_q <= 1'b1;
            w_have_q <= 1'b0;
        end
    end

    // write response
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            bvalid_q <= 1'b0;
            bresp_q <= tmr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
        end else if (bvalid_q && S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // read decode; alias addresses read as zero
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
    logic rd_is_ctl, wip_vis;
    assign wip_vis = async_mode & (pend_cnt_q != 2'h0);
    always_comb begin
        rd_data = 32'h00000000;
        rd_resp = tmr_pkg::RESP_OKAY;
        rd_is_ctl = 1'b0;
        if (S_AXI_ARADDR[11:2] == tmr_pkg::CTL_OFS[11:2]) begin
            rd_data = ctl_q & tmr_pkg::CTL_WMASK;
            rd_data[tmr_pkg::CTL_WIP] = wip_vis;
            rd_is_ctl = 1'b1;
        end else if (S_AXI_ARADDR[11:2] == tmr_pkg::CNT_OFS[11:2]) begin
            rd_data = {16'h0000, cnt_q};
        end else if (S_AXI_ARADDR[11:2] == tmr_pkg::PER_OFS[11:2]) begin
            rd_data = {16'h0000, per_q};
        end else if (S_AXI_ARADDR[11:2] == tmr_pkg::STS_OFS[11:2]) begin
            rd_data = {30'h0, sts_q};
        end else if (S_AXI_ARADDR[11:2] == tmr_pkg::IEN_OFS[11:2]) begin
            rd_data = {30'h0, ien_q};
        end else if (S_AXI_ARADDR[11:2] == tmr_pkg::ICLR_OFS[11:2]) begin
            rd_data = 32'h00000000;                                    // write-only
        end else if (S_AXI_ARADDR[11:4] == tmr_pkg::CTL_OFS[11:4] ||
                     S_AXI_ARADDR[11:4] == tmr_pkg::CNT_OFS[11:4] ||
                     S_AXI_ARADDR[11:4] == tmr_pkg::PER_OFS[11:4]) begin
            rd_data = 32'h00000000;
        end else begin
            rd_resp = tmr_pkg::RESP_SLVERR;
        end
    end

    // read channel, one read outstanding
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= tmr_pkg::RESP_OKAY;
            rd_ctl_q <= 1'b0;
        end else if (S_AXI_ARVALID && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_data;
            rresp_q <= rd_resp;
            rd_ctl_q <= rd_is_ctl;
        end else if (rvalid_q && S_AXI_RREADY) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // control register; software keeps off the bus right after clearing enable
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ctl_q <= tmr_pkg::CTL_RST;
        end else if (wr_ctl) begin
            ctl_q <= ctl_new;
        end
    end

    // two-flop synchronisers for pin inputs, plus an edge-detect stage
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ext_m_q <= 1'b0;
            ext_s_q <= 1'b0;
            ext_d_q <= 1'b0;
            gate_m_q <= 1'b0;
            gate_s_q <= 1'b0;
            gate_d_q <= 1'b0;
        end else begin
            ext_m_q <= EXT_COUNT;
            ext_s_q <= ext_m_q;
            ext_d_q <= ext_s_q;
            gate_m_q <= GATE;
            gate_s_q <= gate_m_q;
            gate_d_q <= gate_s_q;
        end
    end

    // count source; with one clock the async path also samples the pin,
    // so external pulses must be wider than one clock period
    logic src_pulse, tick;
    logic [7:0] ps_max;
    always_comb begin
        if (cs) begin
            src_pulse = ext_s_q & ~ext_d_q;
        end else if (gated) begin
            src_pulse = gate_s_q;
        end else begin
            src_pulse = 1'b1;
        end
        case (ps)
            2'h1: ps_max = tmr_pkg::PS_MAX_8;
            2'h2: ps_max = tmr_pkg::PS_MAX_64;
            2'h3: ps_max = tmr_pkg::PS_MAX_256;
            default: ps_max = tmr_pkg::PS_MAX_1;
        endcase
    end
    // >= keeps a prescale change mid-count from running through 255
    assign tick = run & src_pulse & (pre_q >= ps_max);

    // prescaler, cleared while the timer is off, held while stopped
    always_ff @(posedge CLK_SYS) begin
        if (RST || !on) begin
            pre_q <= 8'h00;
        end else if (run && src_pulse) begin
            pre_q <= (pre_q >= ps_max) ? 8'h00 : pre_q + 8'h01;
        end
    end

    // asynchronous count write transfer
    logic land, pend, cnt_load, cnt_accept;
    assign pend = pend_cnt_q != 2'h0;
    assign land = pend_cnt_q == 2'h1;
    assign cnt_accept = wr_cnt & async_mode & ~(blk & pend);
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pend_cnt_q <= 2'h0;
            pend_val_q <= tmr_pkg::CNT_RST;
        end else if (cnt_accept) begin
            pend_cnt_q <= tmr_pkg::ASYNC_WR_CYCLES;
            pend_val_q <= cnt_new32[15:0];
        end else if (pend) begin
            pend_cnt_q <= pend_cnt_q - 2'h1;
        end
    end

    // counter; a landing write outranks a tick
    assign cnt_load = (wr_cnt & ~async_mode) | land;
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cnt_q <= tmr_pkg::CNT_RST;
        end else if (wr_cnt && !async_mode) begin
            cnt_q <= cnt_new32[15:0];
        end else if (land) begin
            cnt_q <= pend_val_q;
        end else if (tick) begin
            cnt_q <= (cnt_q == per_q) ? 16'h0000 : cnt_q + 16'h0001;
        end
    end

    // period register
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            per_q <= tmr_pkg::PER_RST;
        end else if (wr_per) begin
            per_q <= per_new32[15:0];
        end
    end

    // interrupt events; a set in the clearing cycle wins
    logic [1:0] sts_set, sts_clr;
    assign sts_set[tmr_pkg::STS_WRAP] = tick & (cnt_q == per_q) & ~cnt_load;
    assign sts_set[tmr_pkg::STS_GFALL] = on & gated & gate_d_q & ~gate_s_q;
    assign sts_clr = wr_iclr ? (w_data_q[1:0] & wr_mask[1:0]) : 2'h0;
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sts_q <= tmr_pkg::IRQ_RST;
            ien_q <= tmr_pkg::IRQ_RST;
        end else begin
            sts_q <= (sts_q & ~sts_clr) | sts_set;
            if (wr_ien) begin
                ien_q <= (ien_q & ~wr_mask[1:0]) | (w_data_q[1:0] & wr_mask[1:0]);
            end
        end
    end

    // interrupt output
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sts_q & ien_q);
        end
    end

    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    assign IRQ = irq_q;

    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_off_hold: assert property (!on && !cnt_load |=> $stable(cnt_q))
        else $error("counter moved while disabled");
    a_idle_stop: assert property (on && idle_stop && IDLE && !cnt_load |=> $stable(cnt_q))
        else $error("counter moved in idle with stop set");
    a_wr_block: assert property (wr_cnt && async_mode && blk && pend
        |=> pend_cnt_q == $past(pend_cnt_q) - 2'h1)
        else $error("blocked count write restarted transfer");
    a_wip_busy: assert property ($rose(pend) && blk |-> pend [*3] ##1 !pend)
        else $error("write pending length wrong");
    a_wip_sync: assert property ($rose(rvalid_q) && rd_ctl_q && !$past(async_mode)
        |-> !rdata_q[tmr_pkg::CTL_WIP])
        else $error("write pending visible in sync mode");
    a_prescale_div8: assert property (tick && ps == 2'h1 && !cs && !gate_en
        |=> !tick [*7])
        else $error("1:8 prescale ticked early");
    a_ctl_reserved: assert property ($rose(rvalid_q) && rd_ctl_q
        |-> (rdata_q & ~(tmr_pkg::CTL_WMASK | 32'h00000800)) == 32'h00000000)
        else $error("reserved control bits read nonzero");
    a_period_wrap: assert property (tick && cnt_q == per_q && !cnt_load
        |=> cnt_q == 16'h0000 && sts_q[tmr_pkg::STS_WRAP])
        else $error("period match did not wrap and flag");
    a_gate_fall: assert property (on && gated && gate_d_q && !gate_s_q
        |=> sts_q[tmr_pkg::STS_GFALL])
        else $error("gate fall not flagged");
    a_gate_hold: assert property (run && gated && !gate_s_q && !cnt_load
        |=> $stable(cnt_q))
        else $error("gated count advanced with gate low");
    a_irq_out: assert property ((|(sts_q & ien_q)) |=> IRQ)
        else $error("interrupt not raised");

    c_wrap: cover property (sts_set[tmr_pkg::STS_WRAP]);
    c_gate_fall: cover property (sts_set[tmr_pkg::STS_GFALL]);
    c_async_land: cover property (async_mode && land);
    c_blocked: cover property (wr_cnt && async_mode && blk && pend);
    c_irq: cover property ($rose(IRQ));

endmodule

// >>> verification/tmr_ext_clk_model.sv
/* pin model: external count pulses and a gate window for the timer bench.
   assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/10ps
module tmr_ext_clk_model (
    input wire logic clk, // bench clock
    output logic ext_count, // count pin, low at rest
    output logic gate // gate pin, low at rest
);
    // both pins stand still low outside bursts
    initial ext_count = 1'h0;
    initial gate = 1'h0;
    // each level lasts half clocks so the two-flop sync never misses it
    task automatic pulses(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge clk);
            ext_count <= 1'h1;
            repeat (half) @(posedge clk);
            ext_count <= 1'h0;
        end
    endtask
    // single high gate window of len clocks
    task automatic gate_win(input int len);
        gate <= 1'h1;
        repeat (len) @(posedge clk);
        gate <= 1'h0;
    endtask
endmodule

// >>> verification/test_async_capable_16bit_timer.sv
/* bench for the 16-bit timer: registers, aliases, count modes, async writes, irq.
   assumes tmr_timer16_top with its AXI4-Lite slave and the pin model beside it. */
`timescale 1ns/10ps
module test_async_capable_16bit_timer;
    logic clk = 1'h0, rst = 1'h1, idle = 1'h0, sleep = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rs = 32'h000150B9, av, bv, rdata;
    logic [15:0] mp;
    logic [1:0] rr, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, irq, ext, gate;
    int bad_count = 0, n_checks = 0, cyc = 0, tw = 0;
    int divs[4] = '{1, 8, 64, 256};

    tmr_timer16_top u_dut (
        .CLK_SYS(clk), .RST(rst), .EXT_COUNT(ext), .GATE(gate), .IDLE(idle), .SLEEP(sleep),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .IRQ(irq));
    tmr_ext_clk_model u_ext (.clk(clk), .ext_count(ext), .gate(gate));

    // 40 MHz clock
    always #12.5 clk = ~clk;
    // cycle count; the ceiling cuts off a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            finish_test();
        end
    end
    // next pseudo-random word
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // one compare for register, response and pin results
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // write; address and data each held until taken, cycle of the answer kept in tw
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid);
        rr = bresp; // bready stays high so back-to-back calls never toggle it
        tw = cyc;
    endtask
    // read a register, check response and data
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid);
        chk({30'h0, rresp}, {30'h0, r});
        chk(rdata, e);
    endtask
    // count for n cycles at one setting; ticks worked out from the bus answer cycles
    task automatic run(input logic [31:0] c, input logic [15:0] p, input int n, input int dv);
        int t1;
        int tk;
        wr(12'h620, {16'h0, p});
        wr(12'h610, 32'h0);
        wr(12'h634, 32'h3);
        wr(12'h600, c);
        t1 = tw;
        repeat (n) @(posedge clk);
        wr(12'h600, 32'h0);
        @(posedge clk);
        tk = ((idle && c[13]) || sleep) ? 0 : (tw - t1) / dv;
        rdc(12'h610, tk % (p + 1));
        rdc(12'h630, {31'h0, tk > p});
    endtask
    // verdict and end of run
    task automatic finish_test();
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rdc(12'h600, 32'h0);
        rdc(12'h610, 32'h0);
        rdc(12'h620, 32'hFFFF);
        wr(12'h600, 32'hFFFFFFFF);
        rdc(12'h600, tmr_pkg::CTL_WMASK);
        wr(12'h604, 32'hFFFFFFFF);
        @(posedge clk);
        rdc(12'h600, 32'h0);
        // random period through clear, set and invert aliases
        mp = rs[15:0];
        wr(12'h620, rs);
        for (int op = 1; op < 4; op++) begin
            rs = lfsr(rs);
            wr(12'h620 + 12'(4 * op), rs);
            mp = (op == 1) ? (mp & ~rs[15:0]) : (op == 2) ? (mp | rs[15:0]) : (mp ^ rs[15:0]);
            rdc(12'h620, {16'h0, mp});
        end
        // unmapped address answers with an error
        rdc(12'h700, 32'h0, tmr_pkg::RESP_SLVERR);
        wr(12'h700, rs);
        chk({30'h0, rr}, {30'h0, tmr_pkg::RESP_SLVERR});
        // every prescale ratio, random run length
        for (int i = 0; i < 4; i++) begin
            rs = lfsr(rs);
            run(32'h8000 | (i << 4), 16'hFFFF, 3 * divs[i] + int'(rs[7:0]), divs[i]);
        end
        // wrap at a short period; interrupt masked, enabled, cleared
        run(32'h8000, 16'h4, 20, 1);
        chk({31'h0, irq}, 32'h0);
        wr(12'h638, 32'h3);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(12'h634, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        // idle with and without the stop bit
        idle <= 1'h1;
        run(32'hA000, 16'hFFFF, 20, 1);
        run(32'h8000, 16'hFFFF, 20, 1);
        idle <= 1'h0;
        // sleep halts synchronous counting
        sleep <= 1'h1;
        run(32'h8000, 16'hFFFF, 20, 1);
        sleep <= 1'h0;
        // synchronised pin; gate bit must not matter here
        wr(12'h610, 32'h0);
        wr(12'h600, 32'h8086);
        u_ext.pulses(5, 3);
        repeat (6) @(posedge clk);
        rdc(12'h610, 32'h5);
        // async mode: pending flag while a count write settles
        wr(12'h600, 32'h8002);
        wr(12'h610, 32'h1234);
        rdc(12'h600, 32'h8802);
        repeat (6) @(posedge clk);
        rdc(12'h600, 32'h8002);
        // sleep leaves asynchronous counting running
        sleep <= 1'h1;
        u_ext.pulses(3, 3);
        repeat (6) @(posedge clk);
        sleep <= 1'h0;
        rdc(12'h610, 32'h1237);
        // back-to-back count writes, blocked then accepted
        for (int blk = 1; blk >= 0; blk--) begin
            rs = lfsr(rs);
            av = {16'h0, rs[15:0]};
            bv = {16'h0, rs[31:16]};
            wr(12'h600, 32'h8002 | (blk << 12));
            wr(12'h610, av);
            wr(12'h610, bv);
            repeat (6) @(posedge clk);
            rdc(12'h610, blk ? av : bv);
        end
        // gated accumulation over one gate window
        wr(12'h600, 32'h0);
        @(posedge clk);
        wr(12'h634, 32'h3);
        wr(12'h610, 32'h0);
        wr(12'h600, 32'h8080);
        u_ext.gate_win(37);
        repeat (6) @(posedge clk);
        rdc(12'h610, 32'h25);
        rdc(12'h630, 32'h2);
        finish_test();
    end
endmodule
